// [rtl/wdt_cfg_pkg.sv]
// Types for the watchdog and deadman configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package wdt_cfg_pkg;
    // APB slave phase
    typedef enum logic [1:0] {
        APB_IDLE,
        APB_ACCESS,
        APB_DONE
    } apb_state_t;
endpackage
`default_nettype wire

// [rtl/wdt_cfg_regs.svh]
// Constants for the watchdog and deadman configuration block.
// Assumes a 32-bit APB slave at 10 MHz; included by bare name.
//
// Behaviour
// - Deadman force bit set runs deadman from reset; software cannot stop it.
// - Deadman count code n gives terminal count 2^(n+8); codes 24 and up reserved.
// - Window size 11=25%, 10=37.5%, 01=50%, 00=75% of the period.
// - Watchdog force bit set runs watchdog; software cannot disable it.
// - Window-disable bit one gives non-window mode, zero enforces window mode.
// - Stop-during-flash bit one halts watchdog counter while flash programs.
`ifndef WDT_CFG_REGS_SVH
`define WDT_CFG_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CFG_WORD_OFS 12'h000
`define CTRL_OFS 12'h004
`define KICK_OFS 12'h008
`define STATUS_OFS 12'h00C
`define WDT_CNT_OFS 12'h010
`define DMT_CNT_OFS 12'h014

// ----------------------------------------------------------------
// Configuration word field positions
// ----------------------------------------------------------------
`define DMT_FORCE_BIT 31
`define DMT_SEL_HI 30
`define DMT_SEL_LO 26
`define WIN_SZ_HI 25
`define WIN_SZ_LO 24
`define WDT_FORCE_BIT 23
`define WIN_DIS_BIT 22
`define SPGM_STOP_BIT 21

// ----------------------------------------------------------------
// Control fields, codes and timing
// ----------------------------------------------------------------
`define CTRL_WDT_ON_BIT 0
`define CTRL_DMT_ON_BIT 1
`define KICK_KEY 32'h0000A5A5
`define DMT_SEL_MAX 5'h17
`define DMT_SHIFT_BASE 6'h08
`define WDT_PERIOD_DEF 32'h00001000

`endif

// [rtl/wdt_cfg_top.sv]
// Watchdog and deadman timers steered by a captured configuration word.
// Assumes an APB master on mclk_i and a config word stable around reset.
`include "wdt_cfg_regs.svh"
`default_nettype none
module wdt_cfg_top #(
    parameter int WDT_W = 32,
    parameter logic [31:0] WDT_PERIOD = `WDT_PERIOD_DEF
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Configuration word from nonvolatile storage
    input wire logic [31:0] device_config_word_1_i,
    // Flash programming status
    input wire logic flash_prog_busy_i,
    // Deadman kick from instruction fetch
    input wire logic fetch_kick_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Timeout outputs
    output logic wdt_timeout_o,
    output logic dmt_timeout_o
);
    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (WDT_W != 32) begin : g_bad_width
        $error("WDT_W must be 32");
    end

    // ----------------------------------------------------------------
    // Captured configuration
    // ----------------------------------------------------------------
    logic cfg_taken_r;
    logic [31:0] cfg_r;
    // Take config once at the first edge after reset release
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_taken_r <= 1'b0;
            cfg_r <= 32'h00000000;
        end else if (!cfg_taken_r) begin
            cfg_taken_r <= 1'b1;
            cfg_r <= device_config_word_1_i;
        end
    end

    // Decoded fields
    wire dmt_force = cfg_r[`DMT_FORCE_BIT];
    wire [4:0] dmt_sel = cfg_r[`DMT_SEL_HI:`DMT_SEL_LO];
    wire [1:0] win_sz = cfg_r[`WIN_SZ_HI:`WIN_SZ_LO];
    wire wdt_force = cfg_r[`WDT_FORCE_BIT];
    wire win_dis = cfg_r[`WIN_DIS_BIT];
    wire spgm_stop = cfg_r[`SPGM_STOP_BIT];

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wdt_cfg_pkg::apb_state_t apb_r;
    wire apb_setup = psel_i && !penable_i;
    wire acc = psel_i && penable_i && (apb_r == wdt_cfg_pkg::APB_ACCESS);
    wire wr = acc && pwrite_i;
    wire hit_ctrl = paddr_i == `CTRL_OFS;
    wire hit_kick = paddr_i == `KICK_OFS;
    wire hit_cfg = paddr_i == `CFG_WORD_OFS;
    wire hit_stat = paddr_i == `STATUS_OFS;
    wire hit_wcnt = paddr_i == `WDT_CNT_OFS;
    wire hit_dcnt = paddr_i == `DMT_CNT_OFS;
    wire mapped = hit_ctrl | hit_kick | hit_cfg | hit_stat | hit_wcnt | hit_dcnt;

    // ----------------------------------------------------------------
    // Software enables
    // ----------------------------------------------------------------
    logic wdt_sw_on_r;
    logic dmt_sw_on_r;
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wdt_sw_on_r <= 1'b0;
            dmt_sw_on_r <= 1'b0;
        end else if (wr && hit_ctrl) begin
            wdt_sw_on_r <= pwdata_i[`CTRL_WDT_ON_BIT];
            dmt_sw_on_r <= pwdata_i[`CTRL_DMT_ON_BIT];
        end
    end
    // Force bits override software clears
    wire wdt_on = cfg_taken_r && (wdt_force || wdt_sw_on_r);
    wire dmt_on = cfg_taken_r && (dmt_force || dmt_sw_on_r);

    // ----------------------------------------------------------------
    // Watchdog counter with window
    // ----------------------------------------------------------------
    logic [WDT_W-1:0] wdt_cnt_r;
    logic [WDT_W-1:0] open_at;
    wdt_window_calc #(.WIDTH(WDT_W)) u_win (
        .period_i(WDT_PERIOD),
        .size_sel_i(win_sz),
        .open_at_o(open_at)
    );
    wire wdt_halt = spgm_stop && flash_prog_busy_i;
    wire wdt_kick = wr && hit_kick && (pwdata_i == `KICK_KEY);
    wire early_kick = wdt_kick && !win_dis && (wdt_cnt_r < open_at);
    wire wdt_expire = wdt_on && !wdt_halt && (wdt_cnt_r >= WDT_PERIOD - 32'h1);
    wire wdt_fault = wdt_on && (wdt_expire || early_kick);
    logic wdt_timeout_r;
    // Count, restart on good kick, flag on expiry or early kick
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wdt_cnt_r <= '0;
            wdt_timeout_r <= 1'b0;
        end else begin
            if (!wdt_on || wdt_kick || wdt_fault) begin
                wdt_cnt_r <= '0;
            end else if (!wdt_halt) begin
                wdt_cnt_r <= wdt_cnt_r + 32'h1;
            end
            if (wdt_fault) begin
                wdt_timeout_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Deadman counter
    // ----------------------------------------------------------------
    logic [31:0] dmt_cnt_r;
    logic dmt_timeout_r;
    wire dmt_sel_ok = dmt_sel <= `DMT_SEL_MAX;
    wire [5:0] dmt_shift = {1'b0, dmt_sel} + `DMT_SHIFT_BASE;
    wire [31:0] dmt_term = dmt_sel_ok ? (32'h1 << dmt_shift[4:0]) : 32'h0;
    wire dmt_hit = dmt_on && dmt_sel_ok && (dmt_cnt_r >= dmt_term - 32'h1);
    // Count fetches-free cycles up to terminal count
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dmt_cnt_r <= 32'h00000000;
            dmt_timeout_r <= 1'b0;
        end else begin
            if (!dmt_on || fetch_kick_i || dmt_hit) begin
                dmt_cnt_r <= 32'h00000000;
            end else begin
                dmt_cnt_r <= dmt_cnt_r + 32'h1;
            end
            if (dmt_hit) begin
                dmt_timeout_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // APB read mux and handshake
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    wire [31:0] stat_word = {26'h0, dmt_on, wdt_on, dmt_timeout_r, wdt_timeout_r,
        dmt_sel_ok, cfg_taken_r};
    always_comb begin
        rd_mux = 32'h00000000;
        if (hit_cfg) rd_mux = cfg_r;
        if (hit_ctrl) rd_mux = {30'h0, dmt_sw_on_r, wdt_sw_on_r};
        if (hit_stat) rd_mux = stat_word;
        if (hit_wcnt) rd_mux = wdt_cnt_r;
        if (hit_dcnt) rd_mux = dmt_cnt_r;
    end
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    // No wait state: answer in the cycle after setup
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            apb_r <= wdt_cfg_pkg::APB_IDLE;
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            case (apb_r)
                wdt_cfg_pkg::APB_IDLE: begin
                    if (apb_setup) begin
                        apb_r <= wdt_cfg_pkg::APB_ACCESS;
                        pready_r <= 1'b1;
                        pslverr_r <= !mapped;
                        prdata_r <= pwrite_i ? 32'h00000000 : rd_mux;
                    end
                end
                wdt_cfg_pkg::APB_ACCESS: apb_r <= wdt_cfg_pkg::APB_IDLE;
                default: apb_r <= wdt_cfg_pkg::APB_IDLE;
            endcase
        end
    end
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign wdt_timeout_o = wdt_timeout_r;
    assign dmt_timeout_o = dmt_timeout_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_dmt_forced;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (cfg_taken_r && dmt_force) |-> dmt_on;
    endproperty
    a_dmt_forced: assert property (p_dmt_forced) else $error("deadman not forced on");
    property p_dmt_term;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (dmt_on && dmt_sel_ok && !fetch_kick_i && dmt_cnt_r == dmt_term - 32'h1)
            |=> dmt_timeout_r && dmt_cnt_r == 32'h0;
    endproperty
    a_dmt_term: assert property (p_dmt_term) else $error("deadman missed terminal count");
    property p_win_size;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (win_sz == 2'h1) |-> open_at == (WDT_PERIOD >> 1);
    endproperty
    a_win_size: assert property (p_win_size) else $error("window size wrong");
    property p_wdt_forced;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (cfg_taken_r && wdt_force && wr && hit_ctrl) |=> wdt_on;
    endproperty
    a_wdt_forced: assert property (p_wdt_forced) else $error("watchdog disabled");
    property p_early_kick;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (wdt_on && !win_dis && wdt_kick && wdt_cnt_r < open_at) |=> wdt_timeout_r;
    endproperty
    a_early_kick: assert property (p_early_kick) else $error("early kick not caught");
    property p_nowin;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (win_dis && !wdt_expire && !wdt_timeout_r) |=> !wdt_timeout_r;
    endproperty
    a_nowin: assert property (p_nowin) else $error("non-window mode faulted");
    property p_halt;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (wdt_on && wdt_halt && !wdt_kick && !early_kick) |=> $stable(wdt_cnt_r);
    endproperty
    a_halt: assert property (p_halt) else $error("watchdog ran during flash");
    property p_cfg_hold;
        @(posedge mclk_i) disable iff (sys_rst_i)
        cfg_taken_r |=> $stable(cfg_r);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed while running");

    // ----------------------------------------------------------------
    // Assertions on counting, enables and the bus answer
    // ----------------------------------------------------------------
    // Last watchdog count leads to a flagged expiry and a cleared count
    sequence s_wdt_last;
        wdt_on && !wdt_halt && wdt_cnt_r == WDT_PERIOD - 32'h1;
    endsequence
    sequence s_wdt_fired;
        wdt_timeout_r && wdt_cnt_r == '0;
    endsequence
    property p_wdt_expire;
        @(posedge mclk_i) disable iff (sys_rst_i)
        s_wdt_last |=> s_wdt_fired;
    endproperty
    a_wdt_expire: assert property (p_wdt_expire) else $error("watchdog expiry missed");
    // Opening point as a fraction of the period for every size code
    property p_win_all;
        @(posedge mclk_i) disable iff (sys_rst_i)
        cfg_taken_r |-> open_at == ((win_sz == 2'h3) ? ((WDT_PERIOD * 32'h3) >> 2) :
            (win_sz == 2'h2) ? ((WDT_PERIOD * 32'h5) >> 3) :
            (win_sz == 2'h1) ? (WDT_PERIOD >> 1) : (WDT_PERIOD >> 2));
    endproperty
    a_win_all: assert property (p_win_all) else $error("window opening point wrong");
    // Reserved count codes never time out
    property p_dmt_reserved;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (cfg_taken_r && !dmt_sel_ok && !dmt_timeout_r) |=> !dmt_timeout_r;
    endproperty
    a_dmt_reserved: assert property (p_dmt_reserved) else $error("reserved code timed out");
    // Fetch activity restarts the deadman count
    property p_dmt_kick;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (dmt_on && fetch_kick_i) |=> dmt_cnt_r == 32'h0;
    endproperty
    a_dmt_kick: assert property (p_dmt_kick) else $error("fetch did not restart deadman");
    // Software may start an unforced deadman
    property p_dmt_sw;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (cfg_taken_r && !dmt_force && wr && hit_ctrl && pwdata_i[`CTRL_DMT_ON_BIT]) |=> dmt_on;
    endproperty
    a_dmt_sw: assert property (p_dmt_sw) else $error("deadman not started by software");
    // Software may start an unforced watchdog
    property p_wdt_sw;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (cfg_taken_r && !wdt_force && wr && hit_ctrl && pwdata_i[`CTRL_WDT_ON_BIT]) |=> wdt_on;
    endproperty
    a_wdt_sw: assert property (p_wdt_sw) else $error("watchdog not started by software");
    // Counter advances when not halted, kicked or faulted
    property p_wdt_run;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (wdt_on && !wdt_halt && !wdt_kick && !wdt_fault && !(wr && hit_ctrl))
            |=> wdt_cnt_r == $past(wdt_cnt_r) + 32'h1;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("watchdog failed to count");
    // Config word taken at the first edge after reset
    property p_cfg_take;
        @(posedge mclk_i) disable iff (sys_rst_i)
        !cfg_taken_r |=> cfg_taken_r && cfg_r == $past(device_config_word_1_i);
    endproperty
    a_cfg_take: assert property (p_cfg_take) else $error("config word not captured");
    // Unmapped setup answered with an error in the next cycle
    property p_slverr;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (apb_r == wdt_cfg_pkg::APB_IDLE && apb_setup && !mapped) |=> pready_r && pslverr_r;
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
    // Ready stands for one cycle only
    property p_ready_pulse;
        @(posedge mclk_i) disable iff (sys_rst_i)
        pready_r |=> !pready_r;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
endmodule
`default_nettype wire

// [rtl/wdt_window_calc.sv]
// Window opening point for the watchdog period.
// Assumes a fixed period and a two-bit size code from the config word.
`include "wdt_cfg_regs.svh"
`default_nettype none
module wdt_window_calc #(
    parameter int WIDTH = 32
) (
    // Inputs
    input wire logic [WIDTH-1:0] period_i,
    input wire logic [1:0] size_sel_i,
    // Output
    output logic [WIDTH-1:0] open_at_o
);
    // ----------------------------------------------------------------
    // Open fraction: closed part is the period minus the window
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] q1;
    logic [WIDTH-1:0] q8;
    assign q1 = period_i >> 2;
    assign q8 = period_i >> 3;
    // Window opens at period*(1-fraction)
    always_comb begin
        case (size_sel_i)
            2'h3: open_at_o = period_i - q1;        // 25% open
            2'h2: open_at_o = period_i - q1 - q8;   // 37.5% open
            2'h1: open_at_o = period_i >> 1;        // 50% open
            default: open_at_o = q1;                // 75% open
        endcase
    end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Testbench for the configuration-driven watchdog and deadman block.
// Assumes the rtl/ header on the include path and a 64-cycle watchdog period.
`include "wdt_cfg_regs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // Stimulus and observation
    // ----------------------------------------------------------------
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic flash_prog_busy_i = 1'b0;
    logic fetch_kick_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [31:0] device_config_word_1_i = 32'h00000000;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, wdt_timeout_o, dmt_timeout_o;
    logic [31:0] seed = 32'h00006774;
    logic [32:0] exp_q[$];
    logic [1:0] flag_q[$];
    int opn[4] = '{16, 32, 40, 48};
    int errors = 0;
    int compares = 0;
    int cyc = 0;

    wdt_cfg_top #(.WDT_W(32), .WDT_PERIOD(32'h00000040)) wdt_cfg_top_i (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .device_config_word_1_i(device_config_word_1_i),
        .flash_prog_busy_i(flash_prog_busy_i), .fetch_kick_i(fetch_kick_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .wdt_timeout_o(wdt_timeout_o), .dmt_timeout_o(dmt_timeout_o)
    );

    // Clock, 100 ns period
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end

    // ----------------------------------------------------------------
    // Checking and reporting
    // ----------------------------------------------------------------
    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_apb(input logic [32:0] e, input logic [32:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("mismatch apb_read expected %h seen %h", e, g);
        end
    endtask

    task automatic cmp_flag(input logic [1:0] e, input logic [1:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("mismatch timeouts expected %b seen %b", e, g);
        end
    endtask

    // Read results taken off the queue in order
    always @(posedge mclk_i) begin
        if (pready_o === 1'b1 && pwrite_i === 1'b0 && exp_q.size() > 0) begin
            cmp_apb(exp_q.pop_front(), {pslverr_o, prdata_o});
        end
    end

    // Timeout flags noted by the driver, compared once settled
    always @(negedge mclk_i) begin
        if (flag_q.size() > 0) begin
            cmp_flag(flag_q.pop_front(), {wdt_timeout_o, dmt_timeout_o});
        end
    end

    // Hang guard
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Drivers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Config word with random unused low bits
    function automatic logic [31:0] mk(input logic dmf, input logic [4:0] sel,
        input logic [1:0] win, input logic wdf, input logic wdis, input logic sp);
        logic [31:0] r;
        r = xs();
        return {dmf, sel, win, wdf, wdis, sp, r[20:0]};
    endfunction

    // Reset with a new word, then scramble the input once captured
    task automatic boot(input logic [31:0] cfg);
        sys_rst_i <= 1'b1;
        device_config_word_1_i <= cfg;
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        @(posedge mclk_i);
        device_config_word_1_i <= ~cfg;
    endtask

    // One APB transfer, then one idle cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e = 1'b0);
        exp_q.push_back({e, d});
        apb(1'b0, a, 32'h00000000);
    endtask

    task automatic chk(input int n, input logic [1:0] e);
        repeat (n) @(posedge mclk_i);
        flag_q.push_back(e);
        @(posedge mclk_i);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] c;
        // Forced timers, readback, software off attempt, unmapped place
        c = mk(1'b1, 5'h00, 2'h3, 1'b1, 1'b1, 1'b0);
        boot(c);
        rd(`CFG_WORD_OFS, c);
        rd(`STATUS_OFS, 32'h00000033);
        apb(1'b1, `CTRL_OFS, 32'h00000000);
        rd(`STATUS_OFS, 32'h00000033);
        rd(12'h0FC, 32'h00000000, 1'b1);
        chk(40, 2'b00);
        chk(30, 2'b10);
        chk(150, 2'b10);
        chk(60, 2'b11);
        // Unforced timers stay off until software enables them
        boot(mk(1'b0, 5'h00, 2'h3, 1'b0, 1'b1, 1'b0));
        chk(300, 2'b00);
        rd(`STATUS_OFS, 32'h00000003);
        apb(1'b1, `CTRL_OFS, 32'h00000003);
        rd(`CTRL_OFS, 32'h00000003);
        chk(100, 2'b10);
        chk(200, 2'b11);
        // Deadman terminal counts
        for (int s = 0; s < 3; s++) begin
            boot(mk(1'b1, 5'(s), 2'h3, 1'b0, 1'b1, 1'b0));
            chk((1 << (s + 8)) - 12, 2'b00);
            chk(24, 2'b01);
        end
        // Fetch kick restarts the deadman count
        boot(mk(1'b1, 5'h00, 2'h3, 1'b0, 1'b1, 1'b0));
        chk(200, 2'b00);
        fetch_kick_i <= 1'b1;
        @(posedge mclk_i);
        fetch_kick_i <= 1'b0;
        chk(240, 2'b00);
        chk(30, 2'b01);
        // Reserved count code never expires
        c = xs();
        boot(mk(1'b1, 5'h18 | 5'(c[2:0]), 2'h3, 1'b0, 1'b1, 1'b0));
        rd(`STATUS_OFS, 32'h00000021);
        chk(600, 2'b00);
        // Window sizes: early kick faults, late kick holds off expiry
        for (int w = 0; w < 4; w++) begin
            boot(mk(1'b0, 5'h00, 2'(w), 1'b1, 1'b0, 1'b0));
            chk(opn[w] - 6, 2'b00);
            apb(1'b1, `KICK_OFS, `KICK_KEY);
            chk(8, 2'b10);
            boot(mk(1'b0, 5'h00, 2'(w), 1'b1, 1'b0, 1'b0));
            chk(opn[w] + 4, 2'b00);
            apb(1'b1, `KICK_OFS, `KICK_KEY);
            chk(50, 2'b00);
        end
        // Non-window mode accepts early kicks
        boot(mk(1'b0, 5'h00, 2'h3, 1'b1, 1'b1, 1'b0));
        chk(3, 2'b00);
        apb(1'b1, `KICK_OFS, `KICK_KEY);
        chk(40, 2'b00);
        apb(1'b1, `KICK_OFS, `KICK_KEY);
        chk(50, 2'b00);
        // Flash programming halts the watchdog only when selected
        for (int s = 0; s < 2; s++) begin
            flash_prog_busy_i <= 1'b1;
            boot(mk(1'b0, 5'h00, 2'h3, 1'b1, 1'b1, 1'(s)));
            chk(150, (s == 1) ? 2'b00 : 2'b10);
            flash_prog_busy_i <= 1'b0;
            chk(80, 2'b10);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
